// file: bench/fmc_line_model.sv
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// Line side: limited tone, one half period per edge
// ============================================================
module fmc_line_model (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [10:0] half_us,
    output logic             rx_sq
);
    int cnt;
    int cur;

    // Next half period latched at each edge; zero keeps the line quiet
    always @(negedge clk) begin
        if (srst) begin
            rx_sq <= 1'b0;
            cnt   <= 0;
            cur   <= 0;
        end else if (cur == 0) begin
            cnt <= 0;
            cur <= int'(half_us);
        end else if (cnt + 1 >= cur * fmc_pkg::REF_DIV) begin
            rx_sq <= ~rx_sq;
            cnt   <= 0;
            cur   <= int'(half_us);
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : fmc_line_model

`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    logic                  clk = 1'b0;
    logic                  srst = 1'b1;
    logic                  answer_mode = 1'b0;
    logic                  tx_bit = 1'b0;
    logic                  rx_ready = 1'b0;
    logic                  overrun_clr = 1'b0;
    logic                  rx_sq;
    logic [2:0]            tx_level;
    logic                  rx_bit;
    logic                  rx_valid;
    logic                  rx_overrun;
    fmc_pkg::fmc_rx_word_t rx_word;
    logic [10:0]           half_in = 11'h000;
    logic                  drain = 1'b0;
    logic                  skip = 1'b0;
    logic                  exp_bit = 1'b0;
    logic                  last_sq = 1'b0;
    logic                  m;
    logic [2:0]            prev_lvl = 3'h4;
    logic [7:0]            seen_lvl = 8'h00;
    int failures = 0, checks = 0, seed = 30804;
    int since = 0, n_edges = 0, bit_due = 0, pops = 0, h, thr, e;
    int cyc = 0, n_cross = 0, t_cross = 0, big_step = 0;
    int expq[$];
    int hi_half[5] = '{225, 247, 234, 238, 247};

    always #20 clk = ~clk;

    fmc_modem dut_u (.clk(clk), .srst(srst), .answer_mode(answer_mode), .tx_bit(tx_bit),
        .tx_level(tx_level), .rx_sq(rx_sq), .rx_bit(rx_bit), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_word(rx_word), .overrun_clr(overrun_clr),
        .rx_overrun(rx_overrun));

    fmc_line_model line_u (.clk(clk), .srst(srst), .half_us(half_in), .rx_sq(rx_sq));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic wrap_up;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    // ============================================================
    // Receive reference model: interval length decides each word
    // ============================================================
    always @(negedge clk) rx_ready <= drain && (($random(seed) & 3) != 0);

    always @(posedge clk) begin
        if (srst) begin
            // Timer idles saturated after reset, so the first word reads long
            since = 1024 * fmc_pkg::REF_DIV;
            last_sq = 1'b0;
        end else begin
            since++;
            if (rx_sq !== last_sq) begin
                h = since / fmc_pkg::REF_DIV;
                h = (h > 1023) ? 1023 : h;
                thr = answer_mode ? 429 : 236;
                m = (h < thr);
                // Edges off the tick grid give an uncertain count
                e = (since % fmc_pkg::REF_DIV == 0 || h == 1023) ? h * 2 + int'(m) : -1;
                expq.push_back(e);
                exp_bit = m;
                bit_due = (e >= 0) ? 3 : 0;
                since = 0;
                last_sq = rx_sq;
                n_edges++;
            end else if (bit_due > 0) begin
                bit_due--;
                if (bit_due == 0) check("rx_bit", rx_bit, exp_bit);
            end
            if (rx_valid && rx_ready) begin
                pops++;
                if (!skip && expq.size() > 0) begin
                    e = expq.pop_front();
                    if (e >= 0) begin
                        check("rx_mark", rx_word.mark, e % 2);
                        check("rx_half", rx_word.half_us + 1 >= e / 2 && rx_word.half_us <= e / 2 + 1, 1);
                    end
                end
            end
        end
    end

    // ============================================================
    // Transmit observation: mid-level crossings and step sizes
    // ============================================================
    always @(posedge clk) begin
        cyc++;
        if (!srst) begin
            seen_lvl[tx_level] = 1'b1;
            if ((prev_lvl < 4) != (tx_level < 4)) begin
                n_cross++;
                t_cross = cyc;
            end
            if (tx_level > prev_lvl + 2 || prev_lvl > tx_level + 2) big_step++;
            prev_lvl = tx_level;
        end
    end

    task automatic give_up;
        check("timeout", 0, 1);
        wrap_up();
    endtask : give_up

    task automatic next_cross(output int t);
        int c, k;
        c = n_cross;
        for (k = 0; k < 30000 && n_cross == c; k++) @(negedge clk);
        if (n_cross == c) give_up();
        else t = t_cross;
    endtask : next_cross

    // Half period quantised to the 1 us tick, so one tick of slack
    task automatic half_chk(input int d, input int f);
        int x;
        x = fmc_pkg::CLK_HZ / 2 / f;
        check("tx_half", d >= x - x / 1000 - 26 && d <= x + x / 1000 + 26, 1);
    endtask : half_chk

    task automatic tone_pair(input int f_space, input int f_mark);
        int t0, t1, t2;
        tx_bit = 1'b0;
        next_cross(t0);
        next_cross(t1);
        half_chk(t1 - t0, f_space);
        tx_bit = 1'b1;
        next_cross(t2);
        half_chk(t2 - t1, f_mark);
    endtask : tone_pair

    task automatic send(input int hv);
        int s, k;
        half_in <= hv[10:0];
        s = n_edges;
        for (k = 0; k < 40000 && n_edges == s; k++) @(negedge clk);
        if (n_edges == s) give_up();
    endtask : send

    initial begin
        repeat (10) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        check("tx_level_rst", tx_level, fmc_pkg::LVL_RST);
        check("rx_rst", {rx_bit, rx_valid, rx_overrun, rx_word}, 0);
        drain = 1'b1;
        answer_mode = 1'b0;
        fork
            tone_pair(1070, 1270);
            begin
                foreach (hi_half[i]) send(hi_half[i]);
                send(0);
            end
        join
        answer_mode = 1'b1;
        fork
            tone_pair(2025, 2225);
            begin
                send(393);
                send(467);
                send(431);
                send(427);
                send(0);
            end
        join
        check("tx_steps", big_step, 0);
        check("tx_levels", seen_lvl, 8'hff);
        check("ovr_idle", rx_overrun, 0);
        // ========================================================
        // Stall the consumer until the buffer refuses
        // ========================================================
        drain = 1'b0;
        repeat (40) send(10);
        send(0);
        check("ovr_set", rx_overrun, 1);
        overrun_clr = 1'b1;
        @(negedge clk);
        overrun_clr = 1'b0;
        @(negedge clk);
        check("ovr_clr", rx_overrun, 0);
        skip = 1'b1;
        pops = 0;
        drain = 1'b1;
        repeat (300) @(negedge clk);
        check("fifo_fill", pops, fmc_pkg::FIFO_DEPTH + 1);
        check("fifo_empty", rx_valid, 0);
        wrap_up();
    end
endmodule : tb_top

`default_nettype wire

// file: core/fmc_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module fmc_fifo #(
    parameter int WIDTH = fmc_pkg::RX_WORD_W,
    parameter int DEPTH = fmc_pkg::FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
        $error("fmc_fifo: DEPTH must be a power of two and WIDTH positive");
    end

    typedef struct packed {
        logic [AW-1:0]    wptr;
        logic [AW-1:0]    rptr;
        logic [AW:0]      count;
        logic             out_valid;
        logic [WIDTH-1:0] out_data;
    } fmc_fifo_state_t;

    fmc_fifo_state_t  st_r;
    fmc_fifo_state_t  st_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             load;
    logic [AW:0]      fill;

    // ========================================================================
    // Storage
    // ========================================================================
    // Output register counts toward depth, so DEPTH words at most
    assign fill      = st_r.count + (AW+1)'(st_r.out_valid);
    assign in_ready  = fill < (AW+1)'(DEPTH);
    assign push      = in_valid && in_ready;
    assign load      = (st_r.count != '0) && (!st_r.out_valid || out_ready);
    assign out_valid = st_r.out_valid;
    assign out_data  = st_r.out_data;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[st_r.wptr] <= in_data;
        end
    end

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.wptr = st_r.wptr + AW'(1);
        end
        if (load) begin
            st_nxt.rptr     = st_r.rptr + AW'(1);
            st_nxt.out_data = mem[st_r.rptr];
        end
        st_nxt.count = st_r.count + (AW+1)'(push) - (AW+1)'(load);
        if (load) begin
            st_nxt.out_valid = 1'b1;
        end else if (out_ready) begin
            st_nxt.out_valid = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ========================================================================
    // Checks
    // ========================================================================
    AST_FIFO_FULL: assert property (@(posedge clk) disable iff (srst)
        fill == (AW+1)'(DEPTH) |-> !in_ready ##1 (fill <= (AW+1)'(DEPTH)))
        else $error("fifo accepts while full");

    AST_FIFO_HOLD: assert property (@(posedge clk) disable iff (srst)
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("fifo output changed while stalled");

endmodule : fmc_fifo

`default_nettype wire

// file: core/fmc_modem.sv
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Originate transmits 1070/1270 Hz low band
// - Answer transmits 2025/2225 Hz high band
// - Tone divided from 1 MHz reference counters
// - Decoder picks eight ladder levels, stepped sine
// - Tone frequency within 0.1 percent
// - Time received half-cycles, decide mark/space
// - Low band: 1270 mark, 1070 space
// - Low-band threshold is 429 us half-cycle
// - Change reported at interval end or next
// - Originate receives 2025/2225 Hz high band
// - Peak jitter about 7.0 / 3.7 percent
// - Higher tone is mark in each band
module fmc_modem #(
    parameter int FIFO_DEPTH = fmc_pkg::FIFO_DEPTH
) (
    input  wire logic                     clk,
    input  wire logic                     srst,
    input  wire logic                     answer_mode,
    input  wire logic                     tx_bit,
    output logic [fmc_pkg::LVL_W-1:0]     tx_level,
    input  wire logic                     rx_sq,
    output logic                          rx_bit,
    output logic                          rx_valid,
    input  wire logic                     rx_ready,
    output fmc_pkg::fmc_rx_word_t         rx_word,
    input  wire logic                     overrun_clr,
    output logic                          rx_overrun
);

    if (fmc_pkg::CLK_HZ % fmc_pkg::REF_HZ != 0
        || fmc_pkg::REF_DIV > (1 << fmc_pkg::REF_CNT_W)
        || fmc_pkg::REF_DIV < 2) begin : g_bad_clk
        $error("fmc_modem: clock is not a usable multiple of the reference");
    end

    fmc_pkg::fmc_state_t              st_r;
    fmc_pkg::fmc_state_t              st_nxt;
    logic [fmc_pkg::ACC_W-1:0]        tx_inc;
    logic [fmc_pkg::HALF_W-1:0]       rx_thr;
    logic                             rx_edge;
    logic                             rx_mark;
    logic                             fifo_in_ready;
    logic [fmc_pkg::RX_WORD_W-1:0]    fifo_out;

    // ========================================================================
    // Tone and threshold selection
    // ========================================================================
    always_comb begin
        if (answer_mode) begin
            tx_inc = tx_bit ? fmc_pkg::INC_HI_MARK : fmc_pkg::INC_HI_SPACE;
            rx_thr = fmc_pkg::LO_THR_CNT;
        end else begin
            tx_inc = tx_bit ? fmc_pkg::INC_LO_MARK : fmc_pkg::INC_LO_SPACE;
            rx_thr = fmc_pkg::HI_THR_CNT;
        end
    end

    assign rx_edge = rx_sq != st_r.rx_prev;
    // Short half-cycle means the higher tone
    assign rx_mark = st_r.half_cnt < rx_thr;

    // ========================================================================
    // Next state
    // ========================================================================
    always_comb begin
        st_nxt = st_r;

        // Reference tick every REF_DIV clocks
        st_nxt.ref_tick = 1'b0;
        if (st_r.ref_cnt == fmc_pkg::REF_CNT_W'(fmc_pkg::REF_DIV - 1)) begin
            st_nxt.ref_cnt  = '0;
            st_nxt.ref_tick = 1'b1;
        end else begin
            st_nxt.ref_cnt = st_r.ref_cnt + fmc_pkg::REF_CNT_W'(1);
        end

        // Phase counter steps at the reference rate; rounding of the
        // increment keeps every tone far inside tolerance
        if (st_r.ref_tick) begin
            st_nxt.acc = st_r.acc + tx_inc;
        end
        st_nxt.tx_level = fmc_pkg::sine_level(
            st_r.acc[fmc_pkg::ACC_W-1 -: fmc_pkg::PH_W]);

        // Half-cycle timer, saturating so a dead line cannot wrap to mark
        st_nxt.rx_prev = rx_sq;
        if (rx_edge) begin
            st_nxt.half_cnt = fmc_pkg::HALF_RST;
        end else if (st_r.ref_tick && st_r.half_cnt != fmc_pkg::HALF_MAX) begin
            st_nxt.half_cnt = st_r.half_cnt + fmc_pkg::HALF_W'(1);
        end

        // Decision only at the end of each half-cycle; 1 us
        // quantisation adds to the inherent quarter-cycle jitter
        if (rx_edge) begin
            st_nxt.rx_bit = rx_mark;
        end

        // One-word holding stage ahead of the buffer
        if (st_r.pend_valid && fifo_in_ready) begin
            st_nxt.pend_valid = 1'b0;
        end
        if (rx_edge) begin
            st_nxt.pend_valid        = 1'b1;
            st_nxt.pend_word.mark    = rx_mark;
            st_nxt.pend_word.half_us = st_r.half_cnt;
        end

        // Set wins over clear
        if (overrun_clr) begin
            st_nxt.overrun = 1'b0;
        end
        if (rx_edge && st_r.pend_valid && !fifo_in_ready) begin
            st_nxt.overrun = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r          <= '0;
            st_r.acc      <= fmc_pkg::ACC_RST;
            st_r.tx_level <= fmc_pkg::LVL_RST;
            st_r.half_cnt <= fmc_pkg::HALF_MAX;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ========================================================================
    // Outputs and buffer
    // ========================================================================
    assign tx_level   = st_r.tx_level;
    assign rx_bit     = st_r.rx_bit;
    assign rx_overrun = st_r.overrun;
    assign rx_word    = fmc_pkg::fmc_rx_word_t'(fifo_out);

    fmc_fifo #(
        .WIDTH (fmc_pkg::RX_WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .srst      (srst),
        .in_valid  (st_r.pend_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (st_r.pend_word),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (fifo_out)
    );

    // ========================================================================
    // Checks
    // ========================================================================
    sequence s_lo_space;
        rx_edge && answer_mode && st_r.half_cnt >= fmc_pkg::LO_THR_CNT;
    endsequence

    sequence s_lo_mark;
        rx_edge && answer_mode && st_r.half_cnt < fmc_pkg::LO_THR_CNT;
    endsequence

    sequence s_hi_mark;
        rx_edge && !answer_mode && st_r.half_cnt < fmc_pkg::HI_THR_CNT;
    endsequence

    AST_REF_PERIOD: assert property (@(posedge clk) disable iff (srst)
        st_r.ref_tick |=> !st_r.ref_tick ##24 st_r.ref_tick)
        else $error("reference tick not every 25 clocks");

    AST_ORIG_TONE: assert property (@(posedge clk) disable iff (srst)
        st_r.ref_tick && !answer_mode && tx_bit
        |=> st_r.acc == $past(st_r.acc) + fmc_pkg::INC_LO_MARK)
        else $error("originate mark step wrong");

    AST_ANS_TONE: assert property (@(posedge clk) disable iff (srst)
        st_r.ref_tick && answer_mode && !tx_bit
        |=> st_r.acc == $past(st_r.acc) + fmc_pkg::INC_HI_SPACE)
        else $error("answer space step wrong");

    AST_PHASE_HOLD: assert property (@(posedge clk) disable iff (srst)
        !st_r.ref_tick |=> $stable(st_r.acc))
        else $error("phase moved without reference tick");

    AST_LADDER_PEAK: assert property (@(posedge clk) disable iff (srst)
        st_r.acc[fmc_pkg::ACC_W-1 -: fmc_pkg::PH_W] == fmc_pkg::PH_PEAK
        |=> tx_level == fmc_pkg::LVL_MAX)
        else $error("ladder misses peak");

    AST_LADDER_TROUGH: assert property (@(posedge clk) disable iff (srst)
        st_r.acc[fmc_pkg::ACC_W-1 -: fmc_pkg::PH_W] == fmc_pkg::PH_TROUGH
        |=> tx_level == fmc_pkg::LVL_MIN)
        else $error("ladder misses trough");

    AST_LO_SPACE: assert property (@(posedge clk) disable iff (srst)
        s_lo_space |=> !rx_bit ##1 ($past(rx_edge) || !rx_bit))
        else $error("long low-band half-cycle not space");

    AST_LO_MARK: assert property (@(posedge clk) disable iff (srst)
        s_lo_mark |=> rx_bit)
        else $error("short low-band half-cycle not mark");

    AST_HI_MARK: assert property (@(posedge clk) disable iff (srst)
        s_hi_mark |=> rx_bit && st_r.pend_word.mark)
        else $error("short high-band half-cycle not mark");

    AST_HOLD_BIT: assert property (@(posedge clk) disable iff (srst)
        !rx_edge |=> $stable(rx_bit))
        else $error("data changed inside a half-cycle");

    AST_TIMER_CLR: assert property (@(posedge clk) disable iff (srst)
        rx_edge |=> st_r.half_cnt == fmc_pkg::HALF_RST && st_r.pend_valid)
        else $error("half-cycle timer not restarted");

endmodule : fmc_modem

`default_nettype wire

// file: core/fmc_pkg.sv
package fmc_pkg;

    // ========================================================================
    // Clocking and reference
    // ========================================================================
    localparam int CLK_HZ    = 25_000_000;
    localparam int REF_HZ    = 1_000_000;
    localparam int REF_DIV   = CLK_HZ / REF_HZ;
    localparam int REF_CNT_W = 5;
    localparam int US_PER_S  = 1_000_000;

    // ========================================================================
    // Transmit tones
    // ========================================================================
    localparam int  ACC_W          = 24;
    localparam int  PH_W           = 4;
    localparam int  LVL_W          = 3;
    localparam int  F_LO_MARK_HZ   = 1270;
    localparam int  F_LO_SPACE_HZ  = 1070;
    localparam int  F_HI_MARK_HZ   = 2225;
    localparam int  F_HI_SPACE_HZ  = 2025;
    localparam int  TONE_TOL_PPM   = 1000;

    // Rounded increment keeps tone error within 0.03 Hz
    function automatic logic [ACC_W-1:0] tone_inc(input longint f_hz);
        longint num;
        num = f_hz * (longint'(1) << ACC_W) + longint'(REF_HZ / 2);
        return ACC_W'(num / longint'(REF_HZ));
    endfunction : tone_inc

    localparam logic [ACC_W-1:0] INC_LO_MARK  = tone_inc(F_LO_MARK_HZ);
    localparam logic [ACC_W-1:0] INC_LO_SPACE = tone_inc(F_LO_SPACE_HZ);
    localparam logic [ACC_W-1:0] INC_HI_MARK  = tone_inc(F_HI_MARK_HZ);
    localparam logic [ACC_W-1:0] INC_HI_SPACE = tone_inc(F_HI_SPACE_HZ);
    localparam logic [ACC_W-1:0] ACC_RST      = 24'h00_0000;
    localparam logic [PH_W-1:0]  PH_PEAK      = 4'h4;
    localparam logic [PH_W-1:0]  PH_TROUGH    = 4'hc;
    localparam logic [LVL_W-1:0] LVL_MAX      = 3'h7;
    localparam logic [LVL_W-1:0] LVL_MIN      = 3'h0;
    localparam logic [LVL_W-1:0] LVL_RST      = 3'h4;

    // Sixteen steps per cycle on eight ladder taps
    function automatic logic [LVL_W-1:0] sine_level(input logic [PH_W-1:0] ph);
        logic [LVL_W-1:0] l;
        l = 3'h4;
        unique case (ph)
            4'h0: l = 3'h4;
            4'h1: l = 3'h5;
            4'h2: l = 3'h6;
            4'h3, 4'h4, 4'h5: l = 3'h7;
            4'h6: l = 3'h6;
            4'h7: l = 3'h5;
            4'h8: l = 3'h3;
            4'h9: l = 3'h2;
            4'ha: l = 3'h1;
            4'hb, 4'hc, 4'hd: l = 3'h0;
            4'he: l = 3'h1;
            4'hf: l = 3'h2;
        endcase
        return l;
    endfunction : sine_level

    // ========================================================================
    // Receive discrimination, counted in reference ticks
    // ========================================================================
    localparam int HALF_W    = 10;
    localparam int LO_THR_US = 429;
    localparam int HI_THR_US = 236;
    localparam logic [HALF_W-1:0] LO_THR_CNT = HALF_W'(LO_THR_US * (REF_HZ / US_PER_S));
    localparam logic [HALF_W-1:0] HI_THR_CNT = HALF_W'(HI_THR_US * (REF_HZ / US_PER_S));
    localparam logic [HALF_W-1:0] HALF_MAX   = 10'h3ff;
    localparam logic [HALF_W-1:0] HALF_RST   = 10'h000;

    // ========================================================================
    // Buffering and carriers
    // ========================================================================
    localparam int FIFO_DEPTH = 32;

    typedef struct packed {
        logic              mark;
        logic [HALF_W-1:0] half_us;
    } fmc_rx_word_t;

    localparam int RX_WORD_W = $bits(fmc_rx_word_t);

    typedef struct packed {
        logic [REF_CNT_W-1:0] ref_cnt;
        logic                 ref_tick;
        logic [ACC_W-1:0]     acc;
        logic [LVL_W-1:0]     tx_level;
        logic                 rx_prev;
        logic [HALF_W-1:0]    half_cnt;
        logic                 rx_bit;
        logic                 pend_valid;
        fmc_rx_word_t         pend_word;
        logic                 overrun;
    } fmc_state_t;

endpackage : fmc_pkg
